// ### verilog/utc_time_formatter.sv
// utc time formatter: local timebase, rounding, week resolution and pulse report
`timescale 1ns/1ns
module utc_time_formatter
#(
  parameter int TICK_CYCLES_P = utc_fmt_pkg::TICK_CYCLES,
  parameter logic [15:0] ROLLOVER_WEEK_P = utc_fmt_pkg::ROLLOVER_WEEK_DEFAULT
)
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic text_compat_select_i,
  input wire logic rollover_override_i,
  input wire logic [15:0] rollover_week_setting_i,
  input wire logic [2:0] utc_variant_select_i,
  input wire logic [3:0] gnss_enable_i,
  input wire logic rtc_running_i,
  input wire logic [11:0] rtc_year_i,
  input wire logic [3:0] rtc_month_i,
  input wire logic [4:0] rtc_day_i,
  input wire logic [4:0] rtc_hour_i,
  input wire logic [5:0] rtc_minute_i,
  input wire logic [5:0] rtc_second_i,
  input wire logic gnss_load_i,
  input wire logic [19:0] week_seconds_count_i,
  input wire logic [29:0] load_ns_i,
  input wire logic [11:0] load_year_i,
  input wire logic [3:0] load_month_i,
  input wire logic [4:0] load_day_i,
  input wire logic [9:0] load_bcast_week_i,
  input wire logic load_alt_week_valid_i,
  input wire logic [15:0] load_alt_week_i,
  input wire logic [2:0] load_source_i,
  input wire logic leap_add_i,
  input wire logic leap_sub_i,
  input wire logic pulse_enable_i,
  input wire logic [15:0] pulse_period_ms_i,
  input wire logic [15:0] pulse_length_ms_i,
  output logic tick_o,
  output utc_fmt_pkg::time_state_t time_state_o,
  output logic [11:0] utc_year_o,
  output logic [3:0] utc_month_o,
  output logic [4:0] utc_day_o,
  output logic [4:0] utc_hour_o,
  output logic [5:0] utc_minute_o,
  output logic [5:0] utc_second_o,
  output logic signed [31:0] utc_nano_o,
  output logic [9:0] text_frac_o,
  output logic [1:0] text_frac_len_o,
  output logic [15:0] full_week_o,
  output logic [29:0] week_ms_o,
  output logic [2:0] day_of_week_o,
  output logic [2:0] utc_source_o,
  output utc_fmt_pkg::utc_variant_t utc_variant_o,
  output logic timepulse_o,
  output logic next_pulse_valid_o,
  output logic [29:0] next_pulse_week_ms_o,
  output logic [15:0] next_pulse_week_o,
  output logic [2:0] next_pulse_source_o
);
  import utc_fmt_pkg::*;

  logic [14:0] tick_count;
  time_state_t state;
  logic seed_pending;
  logic [11:0] cur_year;
  logic [3:0] cur_month;
  logic [4:0] cur_day;
  logic [4:0] cur_hour;
  logic [5:0] cur_minute;
  logic [5:0] cur_second;
  logic [29:0] frac_ns;
  logic [29:0] next_frac;
  logic sec_step;
  logic [11:0] step_year;
  logic [3:0] step_month;
  logic [4:0] step_day;
  logic [4:0] step_hour;
  logic [5:0] step_minute;
  logic [5:0] step_second;
  logic [16:0] sod;
  logic [16:0] sod_rem;
  logic [4:0] load_hour;
  logic [5:0] load_minute;
  logic [5:0] load_second;
  logic [15:0] ref_week;
  logic [9:0] week_delta;
  logic [29:0] load_week_ms;
  logic [29:0] centi_full;
  logic [29:0] centi_rem;
  logic [6:0] centi;
  logic round_up;
  logic carry_sec;
  logic [6:0] centi_shown;
  logic pulse_start;
  logic [29:0] period_ms_ext;
  logic [29:0] next_pulse_sum;

  // 1 kHz tick from the system clock
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      tick_count <= 15'h0000;
    else if (tick_o)
      tick_count <= 15'h0000;
    else
      tick_count <= tick_count + 15'h0001;
  end
  assign tick_o = tick_count == 15'(TICK_CYCLES_P - 1);

  // sub-second advance in millisecond steps
  always_comb
  begin
    next_frac = frac_ns + NS_PER_TICK;
    sec_step = 1'b0;
    if (next_frac >= NS_PER_SEC)
    begin
      next_frac = next_frac - NS_PER_SEC;
      sec_step = 1'b1;
    end
  end

  // next second of the local calendar
  cal_step u_local_step (
    .year_i(cur_year),
    .month_i(cur_month),
    .day_i(cur_day),
    .hour_i(cur_hour),
    .minute_i(cur_minute),
    .second_i(cur_second),
    .leap_add_i(leap_add_i),
    .leap_sub_i(leap_sub_i),
    .year_o(step_year),
    .month_o(step_month),
    .day_o(step_day),
    .hour_o(step_hour),
    .minute_o(step_minute),
    .second_o(step_second)
  );

  // time of day from seconds since sunday midnight
  always_comb
  begin
    sod = 17'(week_seconds_count_i % SEC_PER_DAY);
    load_hour = 5'(sod / SEC_PER_HOUR);
    sod_rem = sod % SEC_PER_HOUR;
    load_minute = 6'(sod_rem / 17'(SEC_PER_MIN));
    load_second = 6'(sod_rem % 17'(SEC_PER_MIN));
    load_week_ms = 30'(week_seconds_count_i * MS_PER_SEC) + load_ns_i / NS_PER_TICK;
  end

  // gps week resolution against the reference rollover week
  assign ref_week = rollover_override_i ? rollover_week_setting_i : ROLLOVER_WEEK_P;
  assign week_delta = load_bcast_week_i - ref_week[WEEK_BITS-1:0];

  // knowledge state and local calendar: rtc seed, gnss load, tick advance
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state <= ST_UPTIME;
      seed_pending <= 1'b1;
      cur_year <= RST_YEAR;
      cur_month <= RST_MONTH;
      cur_day <= RST_DAY;
      cur_hour <= 5'h00;
      cur_minute <= 6'h00;
      cur_second <= 6'h00;
      frac_ns <= 30'h00000000;
    end
    else if (gnss_load_i)
    begin
      state <= ST_GNSS;
      seed_pending <= 1'b0;
      cur_year <= load_year_i;
      cur_month <= load_month_i;
      cur_day <= load_day_i;
      cur_hour <= load_hour;
      cur_minute <= load_minute;
      cur_second <= load_second;
      frac_ns <= load_ns_i;
    end
    else if (seed_pending)
    begin
      seed_pending <= 1'b0;
      if (rtc_running_i)
      begin
        state <= ST_RTC;
        cur_year <= rtc_year_i;
        cur_month <= rtc_month_i;
        cur_day <= rtc_day_i;
        cur_hour <= rtc_hour_i;
        cur_minute <= rtc_minute_i;
        cur_second <= rtc_second_i;
        frac_ns <= 30'h00000000;
      end
    end
    else if (tick_o)
    begin
      frac_ns <= next_frac;
      if (sec_step)
      begin
        cur_year <= step_year;
        cur_month <= step_month;
        cur_day <= step_day;
        cur_hour <= step_hour;
        cur_minute <= step_minute;
        cur_second <= step_second;
      end
    end
  end

  // week number, week milliseconds and day of week
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      full_week_o <= ROLLOVER_WEEK_DEFAULT;
      week_ms_o <= 30'h00000000;
      day_of_week_o <= 3'h0;
      utc_source_o <= 3'h0;
    end
    else if (gnss_load_i)
    begin
      if (load_alt_week_valid_i)
        full_week_o <= load_alt_week_i;
      else
        full_week_o <= ref_week + {6'h00, week_delta};
      week_ms_o <= load_week_ms;
      day_of_week_o <= 3'(week_seconds_count_i / SEC_PER_DAY);
      utc_source_o <= load_source_i;
    end
    else if (tick_o)
    begin
      if (week_ms_o == MS_PER_WEEK - 30'h00000001)
      begin
        week_ms_o <= 30'h00000000;
        full_week_o <= full_week_o + 16'h0001;
        day_of_week_o <= 3'h0;
      end
      else
      begin
        week_ms_o <= week_ms_o + 30'h00000001;
        if ((week_ms_o + 30'h00000001) % (30'(SEC_PER_DAY) * MS_PER_SEC) == 30'h00000000)
          day_of_week_o <= day_of_week_o + 3'h1;
      end
    end
  end

  // rounding to hundredths
  always_comb
  begin
    centi_full = frac_ns / NS_PER_CENTI;
    centi_rem = frac_ns % NS_PER_CENTI;
    centi = centi_full[6:0];
    round_up = centi_rem >= HALF_CENTI;
    carry_sec = round_up && centi == CENTI_LAST;
    centi_shown = carry_sec ? 7'h00 : centi + {6'h00, round_up};
  end

  // binary and text views, one set per clock
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      utc_year_o <= RST_YEAR;
      utc_month_o <= RST_MONTH;
      utc_day_o <= RST_DAY;
      utc_hour_o <= 5'h00;
      utc_minute_o <= 6'h00;
      utc_second_o <= 6'h00;
      utc_nano_o <= 32'sh00000000;
      text_frac_o <= 10'h000;
      text_frac_len_o <= FRAC_LEN_TEXT;
      time_state_o <= ST_UPTIME;
    end
    else
    begin
      time_state_o <= state;
      utc_year_o <= carry_sec ? step_year : cur_year;
      utc_month_o <= carry_sec ? step_month : cur_month;
      utc_day_o <= carry_sec ? step_day : cur_day;
      utc_hour_o <= carry_sec ? step_hour : cur_hour;
      utc_minute_o <= carry_sec ? step_minute : cur_minute;
      utc_second_o <= carry_sec ? step_second : cur_second;
      if (carry_sec)
        utc_nano_o <= $signed({2'b00, frac_ns}) - $signed({2'b00, NS_PER_SEC});
      else
        utc_nano_o <= $signed({2'b00, frac_ns});
      if (text_compat_select_i)
      begin
        text_frac_o <= 10'({3'h0, centi_shown} * DECI_SCALE);
        text_frac_len_o <= FRAC_LEN_COMPAT;
      end
      else
      begin
        text_frac_o <= {3'h0, centi_shown};
        text_frac_len_o <= FRAC_LEN_TEXT;
      end
    end
  end

  // utc variant in use, auto picks by enabled constellations
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      utc_variant_o <= UTC_USNO;
    else if (utc_variant_select_i != UTC_AUTO)
      utc_variant_o <= utc_variant_t'(utc_variant_select_i);
    else if (gnss_enable_i[0])
      utc_variant_o <= UTC_USNO;
    else if (gnss_enable_i[1])
      utc_variant_o <= UTC_SU;
    else if (gnss_enable_i[2])
      utc_variant_o <= UTC_NTSC;
    else
      utc_variant_o <= UTC_EU;
  end

  // pulse train on the millisecond tick
  pulse_gen u_pulse (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .tick_i(tick_o),
    .enable_i(pulse_enable_i),
    .period_ms_i(pulse_period_ms_i),
    .length_ms_i(pulse_length_ms_i),
    .pulse_o(timepulse_o),
    .start_o(pulse_start)
  );

  // next pulse report at each pulse start
  assign period_ms_ext = {14'h0000, pulse_period_ms_i};
  assign next_pulse_sum = week_ms_o + period_ms_ext;
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      next_pulse_valid_o <= 1'b0;
      next_pulse_week_ms_o <= 30'h00000000;
      next_pulse_week_o <= 16'h0000;
      next_pulse_source_o <= 3'h0;
    end
    else
    begin
      next_pulse_valid_o <= pulse_start;
      if (pulse_start)
      begin
        next_pulse_source_o <= utc_source_o;
        if (next_pulse_sum >= MS_PER_WEEK)
        begin
          next_pulse_week_ms_o <= next_pulse_sum - MS_PER_WEEK;
          next_pulse_week_o <= full_week_o + 16'h0001;
        end
        else
        begin
          next_pulse_week_ms_o <= next_pulse_sum;
          next_pulse_week_o <= full_week_o;
        end
      end
    end
  end

  // checks on the formatted outputs and the timebase
  AST_NANO_RANGE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    utc_nano_o >= NANO_MIN && utc_nano_o <= NANO_MAX)
    else $error("nano correction out of range");
  AST_TEXT_LEN: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    text_compat_select_i |=> text_frac_len_o == FRAC_LEN_COMPAT && text_frac_o % DECI_SCALE == 10'h000)
    else $error("compat fraction not three digits ending in zero");
  AST_NEG_NANO: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    utc_nano_o < 0 |-> text_frac_o == 10'h000)
    else $error("negative nano without rounded-up second");
  AST_LEAP_ADD: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    tick_o && sec_step && !gnss_load_i && !seed_pending && leap_add_i
    && is_last_day(cur_month, cur_day) && cur_hour == HOUR_LAST && cur_minute == MIN_LAST
    && cur_second == SEC_LAST |=> cur_second == SEC_LEAP ##1 cur_hour == HOUR_LAST)
    else $error("leap second not inserted");
  AST_LEAP_SUB: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    tick_o && sec_step && !gnss_load_i && !seed_pending && leap_sub_i && !leap_add_i
    && is_last_day(cur_month, cur_day) && cur_hour == HOUR_LAST && cur_minute == MIN_LAST
    && cur_second == SEC_LAST - 6'h01 |=> cur_second == 6'h00 && cur_hour == 5'h00)
    else $error("leap second not skipped");
  AST_RTC_SEED: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    seed_pending && rtc_running_i && !gnss_load_i |=> state == ST_RTC ##1 time_state_o == ST_RTC)
    else $error("rtc seed not taken");
  AST_WEEK_GPS: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    gnss_load_i && !load_alt_week_valid_i |=> full_week_o >= $past(ref_week)
    && full_week_o[WEEK_BITS-1:0] == $past(load_bcast_week_i)
    && full_week_o - $past(ref_week) < 16'h0400)
    else $error("gps week resolved wrongly");
  AST_WEEK_ALT: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    gnss_load_i && load_alt_week_valid_i |=> full_week_o == $past(load_alt_week_i))
    else $error("unambiguous week not used");
  AST_TICK_GAP: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    tick_o |=> !tick_o [*8])
    else $error("ticks too close together");
  AST_PULSE_REPORT: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    pulse_start && !gnss_load_i |=> next_pulse_valid_o && next_pulse_source_o == utc_source_o)
    else $error("next pulse report missing");
  AST_SOURCE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    gnss_load_i |=> utc_source_o == $past(load_source_i) ##1 time_state_o == ST_GNSS)
    else $error("clock source not reported");

  // main scenarios
  COV_LEAP_SIXTY: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    utc_second_o == SEC_LEAP);
  COV_NEG_NANO: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    utc_nano_o < 0);
  COV_LOAD_GPS: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    gnss_load_i && !load_alt_week_valid_i);
  COV_PULSE: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    next_pulse_valid_o);
endmodule

// ### verilog/utc_fmt_pkg.sv
// shared constants, types and calendar helpers for the utc time formatter
package utc_fmt_pkg;

  // timebase: the local tick period in its own unit, cycles derived from the clock rate
  localparam int CLK_HZ = 20_000_000;
  localparam int TICK_PERIOD_US = 1000;
  localparam int TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_PERIOD_US;

  // nanosecond and millisecond scales
  localparam logic [29:0] NS_PER_TICK = 30'h00f4240;
  localparam logic [29:0] NS_PER_SEC = 30'h3b9aca00;
  localparam logic [29:0] NS_PER_CENTI = 30'h0989680;
  localparam logic [29:0] HALF_CENTI = 30'h04c4b40;
  localparam logic [29:0] MS_PER_WEEK = 30'h240c8400;
  localparam logic [29:0] MS_PER_SEC = 30'h00003e8;
  localparam logic signed [31:0] NANO_MIN = -32'sh004c4b40;
  localparam logic signed [31:0] NANO_MAX = 32'sh3b4e7ebf;

  // time-of-week split
  localparam logic [19:0] SEC_PER_DAY = 20'h15180;
  localparam logic [16:0] SEC_PER_HOUR = 17'h00e10;
  localparam logic [11:0] SEC_PER_MIN = 12'h03c;

  // calendar limits and power-up epoch
  localparam logic [5:0] SEC_LAST = 6'h3b;
  localparam logic [5:0] SEC_LEAP = 6'h3c;
  localparam logic [5:0] MIN_LAST = 6'h3b;
  localparam logic [4:0] HOUR_LAST = 5'h17;
  localparam logic [3:0] MONTH_JUN = 4'h6;
  localparam logic [3:0] MONTH_DEC = 4'hc;
  localparam logic [4:0] DAY_JUN_END = 5'h1e;
  localparam logic [4:0] DAY_DEC_END = 5'h1f;
  localparam logic [11:0] RST_YEAR = 12'h7bc;
  localparam logic [3:0] RST_MONTH = 4'h1;
  localparam logic [4:0] RST_DAY = 5'h06;

  // text fraction formatting
  localparam logic [1:0] FRAC_LEN_TEXT = 2'h2;
  localparam logic [1:0] FRAC_LEN_COMPAT = 2'h3;
  localparam logic [6:0] CENTI_LAST = 7'h63;
  localparam logic [9:0] DECI_SCALE = 10'h00a;

  // gps week handling
  localparam int WEEK_BITS = 10;
  localparam logic [15:0] ROLLOVER_WEEK_DEFAULT = 16'h0800;

  // time knowledge, one-hot
  typedef enum logic [2:0] {
    ST_UPTIME = 3'b001,
    ST_RTC = 3'b010,
    ST_GNSS = 3'b100
  } time_state_t;

  // utc variant codes
  typedef enum logic [2:0] {
    UTC_AUTO = 3'h0,
    UTC_USNO = 3'h1,
    UTC_SU = 3'h2,
    UTC_NTSC = 3'h3,
    UTC_EU = 3'h4
  } utc_variant_t;

  // days in a month, gregorian leap years
  function automatic logic [4:0] days_in_month(input logic [11:0] y, input logic [3:0] m);
    logic leap;
    leap = ((y % 12'h004) == 12'h000 && (y % 12'h064) != 12'h000) || (y % 12'h190) == 12'h000;
    case (m)
      4'h2: days_in_month = leap ? 5'h1d : 5'h1c;
      4'h4, 4'h6, 4'h9, 4'hb: days_in_month = 5'h1e;
      default: days_in_month = 5'h1f;
    endcase
  endfunction

  // june 30th or december 31st
  function automatic logic is_last_day(input logic [3:0] m, input logic [4:0] d);
    is_last_day = (m == MONTH_JUN && d == DAY_JUN_END) || (m == MONTH_DEC && d == DAY_DEC_END);
  endfunction

endpackage

// ### verilog/cal_step.sv
// one-second calendar advance with leap second insertion and deletion
`timescale 1ns/1ns
module cal_step
  import utc_fmt_pkg::*;
(
  input wire logic [11:0] year_i,
  input wire logic [3:0] month_i,
  input wire logic [4:0] day_i,
  input wire logic [4:0] hour_i,
  input wire logic [5:0] minute_i,
  input wire logic [5:0] second_i,
  input wire logic leap_add_i,
  input wire logic leap_sub_i,
  output logic [11:0] year_o,
  output logic [3:0] month_o,
  output logic [4:0] day_o,
  output logic [4:0] hour_o,
  output logic [5:0] minute_o,
  output logic [5:0] second_o
);
  logic day_end;
  logic roll;

  // second, then carry through minute, hour, day, month, year
  always_comb
  begin
    year_o = year_i;
    month_o = month_i;
    day_o = day_i;
    hour_o = hour_i;
    minute_o = minute_i;
    second_o = second_i + 6'h01;
    roll = 1'b0;
    day_end = is_last_day(month_i, day_i) && hour_i == HOUR_LAST && minute_i == MIN_LAST;
    if (second_i == SEC_LEAP)
      roll = 1'b1;
    else if (day_end && leap_add_i && second_i == SEC_LAST)
      second_o = SEC_LEAP;
    else if (day_end && leap_sub_i && second_i == SEC_LAST - 6'h01)
      roll = 1'b1;
    else if (second_i == SEC_LAST)
      roll = 1'b1;
    if (roll)
    begin
      second_o = 6'h00;
      minute_o = minute_i + 6'h01;
      if (minute_i == MIN_LAST)
      begin
        minute_o = 6'h00;
        hour_o = hour_i + 5'h01;
        if (hour_i == HOUR_LAST)
        begin
          hour_o = 5'h00;
          day_o = day_i + 5'h01;
          if (day_i == days_in_month(year_i, month_i))
          begin
            day_o = 5'h01;
            month_o = month_i + 4'h1;
            if (month_i == MONTH_DEC)
            begin
              month_o = 4'h1;
              year_o = year_i + 12'h001;
            end
          end
        end
      end
    end
  end
endmodule

// ### verilog/pulse_gen.sv
// millisecond-step pulse train with configurable period and length
`timescale 1ns/1ns
module pulse_gen
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic tick_i,
  input wire logic enable_i,
  input wire logic [15:0] period_ms_i,
  input wire logic [15:0] length_ms_i,
  output logic pulse_o,
  output logic start_o
);
  logic [15:0] ms_count;
  logic wrap;

  // period 0 wraps on every tick, as period 1 does
  assign wrap = ms_count + 16'h0001 >= period_ms_i;

  // phase counter, restarts when disabled
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ms_count <= 16'h0000;
    else if (!enable_i)
      ms_count <= 16'h0000;
    else if (tick_i)
      ms_count <= wrap ? 16'h0000 : ms_count + 16'h0001;
  end

  // pulse high for the first length_ms of each period
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pulse_o <= 1'b0;
      start_o <= 1'b0;
    end
    else
    begin
      start_o <= enable_i && tick_i && wrap;
      if (!enable_i)
        pulse_o <= 1'b0;
      else if (tick_i)
        // no partial pulse before the first wrap after enable
        pulse_o <= wrap ? (length_ms_i != 16'h0000) : (pulse_o && (ms_count + 16'h0001 < length_ms_i));
    end
  end
endmodule

// ### tb/host_model.sv
// host side model that reads the formatted seconds field
`timescale 1ns/1ns
module host_model
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [5:0] utc_second_i,
  output logic bad_o
);
  // a leap minute may reach second 60, anything above is flagged and held
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      bad_o <= 1'b0;
    else if (utc_second_i > 6'h3c)
      bad_o <= 1'b1;
  end
endmodule

// ### tb/tb_top.sv
// self-checking bench for the utc time formatter
`timescale 1ns/1ns
module tb_top;
  import utc_fmt_pkg::*;
  logic sys_clk_i, rst_n_i, cmp, ovr, rtc, load, alt_v, l_add, l_sub, p_en, bad, tick;
  logic [15:0] ovr_wk, alt_wk, per, len, fwk, npwk;
  logic [11:0] ly, yr;
  logic [3:0] lm, mo;
  logic [4:0] lday, dy, hr;
  logic [5:0] mi, sc;
  logic [19:0] ws;
  logic [29:0] lns;
  logic [9:0] bwk, frac;
  logic [1:0] flen;
  logic [2:0] dow;
  logic signed [31:0] nano;
  logic tp, npv;
  logic [2:0] var_sel, src, usrc, nps;
  logic [3:0] gen;
  logic [11:0] ry;
  logic [5:0] rsec;
  logic [29:0] wms, npms;
  utc_variant_t uvar;
  time_state_t st;
  int num_errors, tests_run, cycles, n, k;
  // design with a short tick so a millisecond is 20 clocks
  utc_time_formatter #(.TICK_CYCLES_P(20)) dut_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .text_compat_select_i(cmp), .rollover_override_i(ovr), .rollover_week_setting_i(ovr_wk),
    .utc_variant_select_i(var_sel), .gnss_enable_i(gen), .rtc_running_i(rtc),
    .rtc_year_i(ry), .rtc_month_i(4'h5), .rtc_day_i(5'h05), .rtc_hour_i(5'h0a),
    .rtc_minute_i(6'h14), .rtc_second_i(rsec), .gnss_load_i(load),
    .week_seconds_count_i(ws), .load_ns_i(lns), .load_year_i(ly), .load_month_i(lm),
    .load_day_i(lday), .load_bcast_week_i(bwk), .load_alt_week_valid_i(alt_v),
    .load_alt_week_i(alt_wk), .load_source_i(src), .leap_add_i(l_add), .leap_sub_i(l_sub),
    .pulse_enable_i(p_en), .pulse_period_ms_i(per), .pulse_length_ms_i(len), .tick_o(tick),
    .time_state_o(st), .utc_year_o(yr), .utc_month_o(mo), .utc_day_o(dy), .utc_hour_o(hr),
    .utc_minute_o(mi), .utc_second_o(sc), .utc_nano_o(nano), .text_frac_o(frac),
    .text_frac_len_o(flen), .full_week_o(fwk), .week_ms_o(wms), .day_of_week_o(dow),
    .utc_source_o(usrc), .utc_variant_o(uvar), .timepulse_o(tp), .next_pulse_valid_o(npv),
    .next_pulse_week_ms_o(npms), .next_pulse_week_o(npwk), .next_pulse_source_o(nps));
  host_model host_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .utc_second_i(sc), .bad_o(bad));
  // 50 ns clock
  initial
  begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk_i);
    #5;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t got %0h want %0h", $time, got, exp);
    end
  endtask
  // load just after a tick so no tick lands before the check
  task automatic ld(input logic [11:0] y, input logic [3:0] m, input logic [4:0] d,
    input logic [19:0] w, input logic [29:0] ns);
    @(posedge sys_clk_i iff tick);
    #5;
    ly = y;
    lm = m;
    lday = d;
    ws = w;
    lns = ns;
    load = 1'b1;
    cyc(1);
    load = 1'b0;
    cyc(1);
  endtask
  task automatic t_round;
    ld(12'h7db, 4'hc, 5'h1f, 20'h93a7f, 30'h3b901ba0);
    chk(yr, 32'h7dc);
    chk(usrc, 32'h2);
    chk({mo, dy, hr, mi, sc}, {4'h1, 5'h01, 5'h00, 6'h00, 6'h00});
    chk(nano, -32'sd700000);
    chk(frac, 32'h0);
    chk(dow, 32'h6);
    $display("round done");
  endtask
  task automatic t_frac;
    ld(12'h7e0, 4'h3, 5'h02, 20'h0e10, 30'h07735940);
    chk({flen, frac}, {2'h2, 10'h00d});
    chk(nano, 32'h07735940);
    cmp = 1'b1;
    ld(12'h7e0, 4'h3, 5'h02, 20'h0e10, 30'h075bcd15);
    chk({flen, frac}, {2'h3, 10'h078});
    chk({hr, mi, sc}, {5'h01, 6'h00, 6'h00});
    cmp = 1'b0;
    $display("fraction done");
  endtask
  task automatic t_week;
    ovr = 1'b1;
    ovr_wk = 16'd1524;
    bwk = 10'd500;
    src = 3'h4;
    ld(12'h7d9, 4'h1, 5'h04, 20'h0, 30'h0);
    chk(fwk, 32'd1524);
    chk(usrc, 32'h4);
    bwk = 10'd499;
    ld(12'h7d9, 4'h1, 5'h04, 20'h0, 30'h0);
    chk(fwk, 32'd2547);
    alt_v = 1'b1;
    alt_wk = 16'd2300;
    ld(12'h7d9, 4'h1, 5'h04, 20'h0, 30'h0);
    chk(fwk, 32'd2300);
    alt_v = 1'b0;
    $display("week done");
  endtask
  task automatic t_leap;
    l_add = 1'b1;
    ld(12'h7df, 4'h6, 5'h1e, 20'h1517f, 30'h3b8b87c0);
    // the second only advances on the next tick
    @(posedge sys_clk_i iff tick);
    cyc(1);
    chk({hr, mi, sc}, {5'h17, 6'h3b, 6'h3c});
    l_add = 1'b0;
    l_sub = 1'b1;
    ld(12'h7df, 4'h6, 5'h1e, 20'h1517e, 30'h3b8b87c0);
    @(posedge sys_clk_i iff tick);
    cyc(1);
    chk({mo, dy, hr, mi, sc}, {4'h7, 5'h01, 5'h00, 6'h00, 6'h00});
    l_sub = 1'b0;
    $display("leap done");
  endtask
  task automatic t_pulse;
    p_en = 1'b1;
    cyc(1);
    while (!tp) cyc(1);
    n = 0;
    while (tp) begin cyc(1); n++; end
    chk(n, 32'd40);
    while (!tp) begin cyc(1); n++; end
    chk(n, 32'd100);
    // next pulse lies one period after the ms of this rise
    k = wms;
    cyc(1);
    chk(npv, 1'b1);
    chk(npms, k + per);
    chk({npwk, nps}, {fwk, src});
    $display("pulse done");
  endtask
  // auto variant follows the enabled constellations, a select overrides it
  task automatic t_var;
    gen = 4'h2;
    cyc(1);
    chk(uvar, UTC_SU);
    gen = 4'h4;
    cyc(1);
    chk(uvar, UTC_NTSC);
    gen = 4'h8;
    cyc(1);
    chk(uvar, UTC_EU);
    var_sel = 3'h1;
    cyc(1);
    chk(uvar, UTC_USNO);
    var_sel = 3'h0;
    gen = 4'h1;
    $display("variant done");
  endtask
  task automatic conclude;
    $display("tests %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // hang guard
  always @(posedge sys_clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      conclude();
    end
  end
  initial
  begin
    {rst_n_i, cmp, ovr, load, alt_v, l_add, l_sub, p_en} = '0;
    {ly, lm, lday, ws, lns, bwk, ovr_wk, alt_wk} = '0;
    rtc = 1'b1;
    var_sel = 3'h0;
    src = 3'h2;
    gen = 4'h1;
    ry = 12'h7e4;
    rsec = 6'h1e;
    per = 16'h0005;
    len = 16'h0002;
    cyc(16);
    rst_n_i = 1'b1;
    cyc(3);
    chk(st, ST_RTC);
    chk({yr, sc}, {12'h7e4, 6'h1e});
    t_round();
    t_frac();
    t_week();
    t_leap();
    t_pulse();
    t_var();
    chk(bad, 1'b0);
    // second reset with the battery clock stopped: no seed is taken
    rtc = 1'b0;
    rst_n_i = 1'b0;
    cyc(2);
    rst_n_i = 1'b1;
    cyc(3);
    chk(st, ST_UPTIME);
    chk({yr, fwk}, {RST_YEAR, ROLLOVER_WEEK_DEFAULT});
    conclude();
  end
endmodule
